// *** rtl/slr_regs.sv ***
`timescale 1ns/1ps
module slr_regs #(
	parameter int TEMP_CYCLES = slr_pkg::TEMP_CYC,
	parameter logic DTW_64 = 1'b0,
	parameter logic LRW_NOSUP = 1'b0,
	parameter logic RW_NOSUP = 1'b0
) (
	input wire logic REF_CLK_I, // system clock
	input wire logic RST_N_I, // sync reset, low
	input wire logic NET_REQ_I, // network access strobe
	input wire logic NET_WR_I, // network write
	input wire logic [15:0] NET_ADR_I, // network byte address
	input wire logic [7:0] NET_WDATA_I, // network write byte
	input wire logic NET_FRAME_END_I, // network frame ended
	input wire logic NET_RW_CMD_I, // combined readwrite cmd
	input wire logic HOST_REQ_I, // host access strobe
	input wire logic HOST_WR_I, // host write
	input wire logic [15:0] HOST_ADR_I, // host byte address
	input wire logic [7:0] HOST_WDATA_I, // host write byte
	input wire logic CFG_LOAD_I, // config load done pulse
	input wire logic CFG_OK_I, // config load correct
	input wire logic [15:0] CFG_WORD0_I, // config word 0
	input wire logic [15:0] CFG_WORD4_I, // config word 4
	input wire logic HOST_OPER_I, // host port operational
	input wire logic [3:0] LINK_UP_I, // per-port link
	input wire logic [3:0] PORT_BUSY_I, // frame on port
	input wire logic [3:0] PORT_VALID_RX_I, // valid frame rx pulse
	output logic [7:0] RDATA_O, // read byte
	output logic RVALID_O, // read answer
	output logic WACC_O, // write accepted
	output logic [15:0] WR_ADR_O, // readwrite write addr
	output logic [15:0] STATION_O, // station address
	output logic [15:0] ALIAS_O, // station alias
	output logic ALIAS_EN_O, // alias matching enabled
	output logic DISCARD_FOREIGN_O, // drop foreign frames
	output logic SRC_LAA_O, // local admin flag
	output logic [3:0] PORT_OPEN_O, // port loop open
	output logic [2:0] FIFO_SIZE_O, // receive fifo size
	output logic LOW_JITTER_O, // reduced jitter
	output logic FEAT_DTW_O, // feature bit 3 copy
	output logic RAM_ACCESS_O, // host ram access allowed
	output logic EV_CLR_O, // clear network event 2
	output logic RST_REQ_O // device reset request
);
	slr_pkg::slr_state_t r, n;
	logic [15:0] feature;

	// ----------------------------------------
	// key sequence step
	// ----------------------------------------
	function automatic slr_pkg::slr_key_t key_step(input slr_pkg::slr_key_t k,
		input logic [7:0] d, output logic fire);
		slr_pkg::slr_key_t res;
		fire = 1'b0;
		res = slr_pkg::SLR_IDLE;
		if (d == slr_pkg::KEY_R) begin
			res = slr_pkg::SLR_GOT_R;
		end else if (d == slr_pkg::KEY_E && k == slr_pkg::SLR_GOT_R) begin
			res = slr_pkg::SLR_GOT_E;
		end else if (d == slr_pkg::KEY_S && k == slr_pkg::SLR_GOT_E) begin
			fire = 1'b1;
		end
		return res;
	endfunction

	function automatic logic [1:0] key_rd(input slr_pkg::slr_key_t k);
		case (k)
			slr_pkg::SLR_GOT_R: key_rd = 2'b01;
			slr_pkg::SLR_GOT_E: key_rd = 2'b10;
			default: key_rd = 2'b00;
		endcase
	endfunction

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	function automatic logic [15:0] rd_word(input logic [15:0] a, input slr_pkg::slr_state_t s,
		input logic [15:0] f);
		logic [15:0] w;
		w = 16'h0000;
		case ({a[15:1], 1'b0})
			slr_pkg::ADR_FEATURE: w = f;
			slr_pkg::ADR_STATION: w = s.station;
			slr_pkg::ADR_ALIAS: w = s.alias_adr;
			slr_pkg::ADR_REG_WEN: w = {7'h00, s.reg_wp, 7'h00, 1'b0};
			slr_pkg::ADR_CTRL_WEN: w = {7'h00, s.ctrl_wp, 7'h00, 1'b0};
			slr_pkg::ADR_NET_RST: w = {6'h00, key_rd(s.host_key), 6'h00, key_rd(s.net_key)};
			slr_pkg::ADR_LINK_CTRL: w = s.ctrl[15:0];
			16'h0102: w = s.ctrl[31:16];
			slr_pkg::ADR_RW_OFS: w = s.rw_ofs;
			slr_pkg::ADR_LINK_STAT: begin
				w[0] = s.cfg_ok & HOST_OPER_I;
				w[2] = s.eld;
				for (int i = 0; i < 4; i++) begin
					w[4 + i] = LINK_UP_I[i];
					w[8 + 2 * i] = ~s.loop_open[i];
				end
			end
			default: w = 16'h0000;
		endcase
		return w;
	endfunction

	always_comb begin
		feature = 16'h0000;
		feature[slr_pkg::FEAT_DTW] = DTW_64;
		feature[slr_pkg::FEAT_LRW] = LRW_NOSUP;
		feature[slr_pkg::FEAT_RW] = RW_NOSUP;
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic net_w;
		logic host_w;
		logic prot_hit;
		logic blocked;
		logic fire_n;
		logic fire_h;
		logic [31:0] wv;
		logic [3:0] want;
		logic [1:0] code;
		net_w = 1'b0;
		host_w = 1'b0;
		prot_hit = 1'b0;
		blocked = 1'b0;
		fire_n = 1'b0;
		fire_h = 1'b0;
		wv = 32'h0000_0000;
		want = 4'h0;
		code = 2'b00;
		n = r;
		n.rvalid = 1'b0;
		n.wacc = 1'b0;
		n.rst_req = 1'b0;
		n.ev_clr = 1'b0;
		if (NET_FRAME_END_I) begin
			n.reg_unl = 1'b0;
			n.ctrl_unl = 1'b0;
		end
		if (NET_REQ_I) begin
			prot_hit = NET_ADR_I <= slr_pkg::ADR_PROT_LAST;
			blocked = (r.reg_wp && !r.reg_unl && prot_hit) || (r.ctrl_wp && !r.ctrl_unl);
			if (NET_ADR_I == slr_pkg::ADR_REG_WEN || NET_ADR_I == slr_pkg::ADR_CTRL_WEN) begin
				blocked = 1'b0;
			end
			if (!NET_WR_I) begin
				n.rvalid = 1'b1;
				n.rdata = rd_word(NET_ADR_I, r, feature);
				if ({NET_ADR_I[15:1], 1'b0} == slr_pkg::ADR_LINK_STAT) begin
					n.ev_clr = 1'b1;
				end
				n.wr_adr = NET_RW_CMD_I ? 16'(NET_ADR_I + r.rw_ofs) : NET_ADR_I;
			end else if (!blocked) begin
				net_w = 1'b1;
				n.wacc = 1'b1;
			end
		end
		if (net_w) begin
			case (NET_ADR_I)
				slr_pkg::ADR_STATION: n.station[7:0] = NET_WDATA_I;
				16'h0011: n.station[15:8] = NET_WDATA_I;
				slr_pkg::ADR_REG_WEN: n.reg_unl = 1'b1;
				slr_pkg::ADR_REG_WP: n.reg_wp = NET_WDATA_I[0];
				slr_pkg::ADR_CTRL_WEN: n.ctrl_unl = 1'b1;
				slr_pkg::ADR_CTRL_WP: n.ctrl_wp = NET_WDATA_I[0];
				slr_pkg::ADR_NET_RST: begin
					n.net_key = key_step(r.net_key, NET_WDATA_I, fire_n);
				end
				slr_pkg::ADR_RW_OFS: n.rw_ofs[7:0] = NET_WDATA_I;
				16'h0109: n.rw_ofs[15:8] = NET_WDATA_I;
				default: begin
					if (NET_ADR_I[15:2] == slr_pkg::ADR_LINK_CTRL[15:2]) begin
						wv = r.ctrl;
						wv[8 * NET_ADR_I[1:0] +: 8] = NET_WDATA_I;
						wv = wv & slr_pkg::LINK_CTRL_MASK;
						if (NET_ADR_I[1:0] == 2'd1 && wv[slr_pkg::CTL_TEMP]) begin
							n.saved_hi = r.ctrl[15:8];
							n.temp_on = 1'b1;
							n.temp_cnt = 28'd0;
						end
						for (int i = 0; i < 4; i++) begin
							if (NET_ADR_I[1:0] == 2'd1 && wv[slr_pkg::CTL_LOOP + 2 * i +: 2] == 2'b01
								&& LINK_UP_I[i]) begin
								n.ac_closed[i] = 1'b0;
							end
						end
						n.ctrl = wv;
					end
				end
			endcase
		end
		if (fire_n) begin
			n.rst_req = 1'b1;
		end
		if (HOST_REQ_I) begin
			host_w = HOST_WR_I;
			if (!HOST_WR_I) begin
				n.rvalid = 1'b1;
				// network read data wins a shared cycle
				if (!(NET_REQ_I && !NET_WR_I)) begin
					n.rdata = rd_word(HOST_ADR_I, r, feature);
				end
			end else begin
				n.wacc = 1'b1;
			end
		end
		if (host_w) begin
			case (HOST_ADR_I)
				slr_pkg::ADR_ALIAS: n.alias_adr[7:0] = HOST_WDATA_I;
				16'h0013: n.alias_adr[15:8] = HOST_WDATA_I;
				slr_pkg::ADR_HOST_RST: begin
					n.host_key = key_step(r.host_key, HOST_WDATA_I, fire_h);
				end
				default: n.wacc = 1'b0;
			endcase
		end
		if (fire_h) begin
			n.rst_req = 1'b1;
		end
		if (r.temp_on) begin
			if (r.temp_cnt == 28'(TEMP_CYCLES - 1)) begin
				n.temp_on = 1'b0;
				n.ctrl[15:8] = r.saved_hi;
			end else begin
				n.temp_cnt = r.temp_cnt + 28'd1;
			end
		end
		if (CFG_LOAD_I) begin
			n.cfg_ok = CFG_OK_I;
			if (!r.loaded_once) begin
				n.loaded_once = 1'b1;
				n.alias_adr = CFG_WORD4_I;
				n.eld = CFG_WORD0_I[slr_pkg::CFG_ELD_BIT];
			end
		end
		for (int i = 0; i < 4; i++) begin
			code = r.ctrl[slr_pkg::CTL_LOOP + 2 * i +: 2];
			if (!LINK_UP_I[i]) begin
				n.ac_closed[i] = 1'b1;
			end else if (PORT_VALID_RX_I[i]) begin
				n.ac_closed[i] = 1'b0;
			end
			case (code)
				2'b00: want[i] = LINK_UP_I[i];
				2'b01: want[i] = LINK_UP_I[i] & ~r.ac_closed[i];
				2'b10: want[i] = 1'b1;
				default: want[i] = 1'b0;
			endcase
			if (!PORT_BUSY_I[i]) begin
				n.loop_open[i] = want[i];
			end
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) begin
			r <= '0;
			r.ctrl <= slr_pkg::LINK_CTRL_RST;
			r.ac_closed <= 4'hF;
		end else begin
			r <= n;
		end
	end

	// ----------------------------------------
	// output registers
	// ----------------------------------------
	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) begin
			RDATA_O <= 8'h00;
			RVALID_O <= 1'b0;
			WACC_O <= 1'b0;
			WR_ADR_O <= 16'h0000;
			STATION_O <= 16'h0000;
			ALIAS_O <= 16'h0000;
			ALIAS_EN_O <= 1'b0;
			DISCARD_FOREIGN_O <= 1'b1;
			SRC_LAA_O <= 1'b0;
			PORT_OPEN_O <= 4'h0;
			FIFO_SIZE_O <= 3'd7;
			LOW_JITTER_O <= 1'b0;
			FEAT_DTW_O <= 1'b0;
			RAM_ACCESS_O <= 1'b0;
			EV_CLR_O <= 1'b0;
			RST_REQ_O <= 1'b0;
		end else begin
			if (n.rvalid) begin
				RDATA_O <= ((NET_REQ_I && !NET_WR_I) ? NET_ADR_I[0] : HOST_ADR_I[0])
					? n.rdata[15:8] : n.rdata[7:0];
			end
			RVALID_O <= n.rvalid;
			WACC_O <= n.wacc;
			WR_ADR_O <= n.wr_adr;
			STATION_O <= r.station;
			ALIAS_O <= r.alias_adr;
			ALIAS_EN_O <= r.ctrl[slr_pkg::CTL_ALIAS];
			DISCARD_FOREIGN_O <= r.ctrl[slr_pkg::CTL_FWD];
			SRC_LAA_O <= 1'b1;
			PORT_OPEN_O <= r.loop_open;
			FIFO_SIZE_O <= r.ctrl[slr_pkg::CTL_FIFO +: 3];
			LOW_JITTER_O <= r.ctrl[slr_pkg::CTL_JIT];
			FEAT_DTW_O <= feature[slr_pkg::FEAT_DTW];
			RAM_ACCESS_O <= r.cfg_ok & HOST_OPER_I;
			EV_CLR_O <= n.ev_clr;
			RST_REQ_O <= n.rst_req;
		end
	end
endmodule

// *** rtl/slr_pkg.sv ***
package slr_pkg;
	localparam logic [15:0] ADR_FEATURE = 16'h0008;
	localparam logic [15:0] ADR_STATION = 16'h0010;
	localparam logic [15:0] ADR_ALIAS = 16'h0012;
	localparam logic [15:0] ADR_REG_WEN = 16'h0020;
	localparam logic [15:0] ADR_REG_WP = 16'h0021;
	localparam logic [15:0] ADR_CTRL_WEN = 16'h0030;
	localparam logic [15:0] ADR_CTRL_WP = 16'h0031;
	localparam logic [15:0] ADR_NET_RST = 16'h0040;
	localparam logic [15:0] ADR_HOST_RST = 16'h0041;
	localparam logic [15:0] ADR_LINK_CTRL = 16'h0100;
	localparam logic [15:0] ADR_RW_OFS = 16'h0108;
	localparam logic [15:0] ADR_LINK_STAT = 16'h0110;
	localparam logic [15:0] ADR_PROT_LAST = 16'h0F0F;
	localparam logic [7:0] KEY_R = 8'h52;
	localparam logic [7:0] KEY_E = 8'h45;
	localparam logic [7:0] KEY_S = 8'h53;
	localparam logic [31:0] LINK_CTRL_RST = 32'h0007_0001;
	localparam logic [31:0] LINK_CTRL_MASK = 32'h010F_FF03;
	localparam int FEAT_DTW = 3;
	localparam int FEAT_LRW = 9;
	localparam int FEAT_RW = 10;
	localparam int CTL_FWD = 0;
	localparam int CTL_TEMP = 1;
	localparam int CTL_LOOP = 8;
	localparam int CTL_FIFO = 16;
	localparam int CTL_JIT = 19;
	localparam int CTL_ALIAS = 24;
	localparam int CFG_ELD_BIT = 9;
	localparam longint TEMP_NS = 64'd1_000_000_000;
	localparam longint CLK_NS = 64'd4;
	localparam int TEMP_CYC = int'(TEMP_NS / CLK_NS);
	typedef enum logic [1:0] {
		SLR_IDLE = 2'b00,
		SLR_GOT_R = 2'b01,
		SLR_GOT_E = 2'b11
	} slr_key_t;
	typedef struct packed {
		logic [15:0] station;
		logic [15:0] alias_adr;
		logic reg_wp;
		logic ctrl_wp;
		logic reg_unl;
		logic ctrl_unl;
		slr_key_t net_key;
		slr_key_t host_key;
		logic [31:0] ctrl;
		logic [7:0] saved_hi;
		logic temp_on;
		logic [27:0] temp_cnt;
		logic [15:0] rw_ofs;
		logic loaded_once;
		logic eld;
		logic cfg_ok;
		logic [3:0] loop_open;
		logic [3:0] ac_closed;
		logic [15:0] rdata;
		logic rvalid;
		logic wacc;
		logic rst_req;
		logic ev_clr;
		logic [15:0] wr_adr;
	} slr_state_t;
endpackage

// *** tb/slr_regs_asserts.sv ***
`timescale 1ns/1ps
module slr_regs_asserts (
	input wire logic REF_CLK_I, // clock
	input wire logic RST_N_I, // reset
	input wire logic NET_REQ_I, // net strobe
	input wire logic NET_WR_I, // net write
	input wire logic [15:0] NET_ADR_I, // net address
	input wire logic [7:0] NET_WDATA_I, // net data
	input wire logic HOST_REQ_I, // host strobe
	input wire logic HOST_WR_I, // host write
	input wire logic [15:0] HOST_ADR_I, // host address
	input wire logic [7:0] HOST_WDATA_I, // host data
	input wire logic RVALID_O, // read answer
	input wire logic WACC_O, // write accepted
	input wire logic [15:0] STATION_O, // station
	input wire logic DISCARD_FOREIGN_O, // drop foreign
	input wire logic SRC_LAA_O, // local admin
	input wire logic [2:0] FIFO_SIZE_O, // fifo size
	input wire logic EV_CLR_O, // event clear
	input wire logic RST_REQ_O // reset request
);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RST_N_I);
	a_read_answer: assert property (
		NET_REQ_I && !NET_WR_I |=> RVALID_O) else $error("read answer missing");
	a_quiet_idle: assert property (
		!NET_REQ_I && !HOST_REQ_I |=> !RVALID_O && !WACC_O) else $error("stray answer");
	a_wacc_cause: assert property (
		WACC_O |-> $past(NET_REQ_I && NET_WR_I || HOST_REQ_I && HOST_WR_I))
		else $error("accept without write");
	a_host_station: assert property (
		HOST_REQ_I && HOST_WR_I && HOST_ADR_I[15:1] == 15'h0008 && !NET_REQ_I |=> !WACC_O)
		else $error("host station write accepted");
	a_station_hold: assert property (
		!(NET_REQ_I && NET_WR_I) |-> ##2 $stable(STATION_O)) else $error("station moved");
	a_key_fire: assert property (
		RST_REQ_O |-> $past(NET_REQ_I && NET_WR_I && NET_WDATA_I == 8'h53
		|| HOST_REQ_I && HOST_WR_I && HOST_WDATA_I == 8'h53)) else $error("reset without key");
	a_key_pulse: assert property (
		RST_REQ_O |=> !RST_REQ_O) else $error("reset pulse too long");
	a_ev_clear: assert property (
		EV_CLR_O |-> $past(NET_REQ_I && !NET_WR_I && NET_ADR_I[15:1] == 15'h0088))
		else $error("event clear without status read");
	a_laa_set: assert property (
		$past(RST_N_I) |-> SRC_LAA_O) else $error("local admin flag low");
	a_reset_vals: assert property (
		$rose(RST_N_I) |-> DISCARD_FOREIGN_O && FIFO_SIZE_O == 3'h7) else $error("control reset");
endmodule

// *** tb/slr_cfg_model.sv ***
`timescale 1ns/1ps
module slr_cfg_model (
	input wire logic clk_i, // clock
	input wire logic go_i, // start a load
	input wire logic [15:0] word4_i, // alias word to serve
	output logic load_o = 1'b0, // load done pulse
	output logic ok_o = 1'b0, // load correct
	output logic [15:0] word0_o = 16'h0000, // config word 0
	output logic [15:0] word4_o = 16'h0000 // config word 4
);
	logic [1:0] cnt = 2'h0;
	// slow fetch; word4 line toggles outside the load pulse, word0 holds
	always @(posedge clk_i) begin
		load_o <= 1'b0;
		word4_o <= ~word4_o;
		if (go_i) begin
			cnt <= 2'h3;
		end else if (cnt != 2'h0) begin
			cnt <= cnt - 2'h1;
			if (cnt == 2'h1) begin
				load_o <= 1'b1;
				ok_o <= 1'b1;
				word0_o <= 16'h0200;
				word4_o <= word4_i;
			end
		end
	end
endmodule

// *** tb/slave_link_config_regs_tb.sv ***
`timescale 1ns/1ps
module slave_link_config_regs_tb;
	logic REF_CLK_I = 1'b0, RST_N_I = 1'b0, NET_REQ_I = 1'b0, NET_WR_I = 1'b0;
	logic NET_FRAME_END_I = 1'b0, NET_RW_CMD_I = 1'b0, HOST_REQ_I = 1'b0, HOST_WR_I = 1'b0;
	logic [15:0] NET_ADR_I = 16'h0000, HOST_ADR_I = 16'h0000, STATION_O, ALIAS_O, WR_ADR_O;
	logic [7:0] NET_WDATA_I = 8'h00, HOST_WDATA_I = 8'h00, RDATA_O, rd;
	logic HOST_OPER_I = 1'b1, CFG_LOAD_I, CFG_OK_I, RVALID_O, WACC_O, ALIAS_EN_O, ok, cfg_go = 1'b0;
	logic [15:0] CFG_WORD0_I, CFG_WORD4_I, alias_val = 16'h0000;
	logic [3:0] LINK_UP_I = 4'h4, PORT_BUSY_I = 4'h0, PORT_VALID_RX_I = 4'h0, PORT_OPEN_O;
	logic DISCARD_FOREIGN_O, SRC_LAA_O, LOW_JITTER_O, FEAT_DTW_O, RAM_ACCESS_O, EV_CLR_O, RST_REQ_O;
	logic [2:0] FIFO_SIZE_O;
	int bad_count = 0, num_checks = 0, rst_cnt = 0, ev_cnt = 0;
	slr_regs #(.TEMP_CYCLES(20)) u_dut (.*);
	slr_cfg_model u_cfg (.clk_i(REF_CLK_I), .go_i(cfg_go), .word4_i(alias_val),
		.load_o(CFG_LOAD_I), .ok_o(CFG_OK_I), .word0_o(CFG_WORD0_I), .word4_o(CFG_WORD4_I));
	initial forever #2 REF_CLK_I = ~REF_CLK_I;
	always @(posedge REF_CLK_I) begin
		if (RST_REQ_O === 1'b1) rst_cnt++;
		if (EV_CLR_O === 1'b1) ev_cnt++;
	end
	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic acc(input logic h, input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge REF_CLK_I);
		NET_REQ_I <= !h;
		HOST_REQ_I <= h;
		NET_WR_I <= w;
		HOST_WR_I <= w;
		NET_ADR_I <= a;
		HOST_ADR_I <= a;
		NET_WDATA_I <= d;
		HOST_WDATA_I <= d;
		@(posedge REF_CLK_I);
		NET_REQ_I <= 1'b0;
		HOST_REQ_I <= 1'b0;
		#1;
		rd = RDATA_O;
		ok = w ? WACC_O : RVALID_O;
	endtask
	task automatic wr(input logic h, input logic [15:0] a, input logic [7:0] d, input logic e);
		acc(h, 1'b1, a, d);
		chk("write accept", 16'(e), 16'(ok));
	endtask
	task automatic rdc(input logic h, input logic [15:0] a, input logic [7:0] e);
		acc(h, 1'b0, a, 8'h00);
		chk("read valid", 16'h0001, 16'(ok));
		chk("read data", 16'(e), 16'(rd));
	endtask
	task automatic frame_end;
		@(posedge REF_CLK_I);
		NET_FRAME_END_I <= 1'b1;
		@(posedge REF_CLK_I);
		NET_FRAME_END_I <= 1'b0;
	endtask
	task automatic cfg_load(input logic [15:0] v);
		int i;
		alias_val = v;
		@(posedge REF_CLK_I);
		cfg_go <= 1'b1;
		@(posedge REF_CLK_I);
		cfg_go <= 1'b0;
		for (i = 0; i < 20 && CFG_LOAD_I !== 1'b1; i++) @(posedge REF_CLK_I);
		if (i == 20) begin
			bad_count++;
			test_done();
		end
	endtask
	task automatic t_reset;
		rdc(0, 16'h0008, 8'h00);
		chk("feature dtw", 16'h0000, 16'(FEAT_DTW_O));
		rdc(1, 16'h0009, 8'h00);
		rdc(0, 16'h0102, 8'h07);
		chk("laa", 16'h0001, 16'(SRC_LAA_O));
		wr(0, 16'h0100, 8'hFF, 1);
		rdc(0, 16'h0100, 8'h03);
		wr(0, 16'h0100, 8'h00, 1);
		rdc(0, 16'h0100, 8'h00);
		chk("discard", 16'h0000, 16'(DISCARD_FOREIGN_O));
		wr(0, 16'h0102, 8'h08, 1);
		rdc(0, 16'h0102, 8'h08);
		chk("jitter", 16'h0001, 16'(LOW_JITTER_O));
		chk("fifo", 16'h0000, 16'(FIFO_SIZE_O));
	endtask
	task automatic t_station;
		wr(0, 16'h0010, 8'h34, 1);
		wr(0, 16'h0011, 8'h12, 1);
		wr(1, 16'h0010, 8'hFF, 0);
		chk("station", 16'h1234, STATION_O);
		wr(0, 16'h0021, 8'h01, 1);
		wr(0, 16'h0010, 8'h00, 0);
		wr(0, 16'h0020, 8'h00, 1);
		wr(0, 16'h0010, 8'h56, 1);
		frame_end();
		wr(0, 16'h0010, 8'h00, 0);
		rdc(1, 16'h0010, 8'h56);
		wr(0, 16'h0020, 8'h00, 1);
		wr(0, 16'h0021, 8'h00, 1);
		wr(0, 16'h0031, 8'h01, 1);
		frame_end();
		wr(0, 16'h0108, 8'h01, 0);
		wr(0, 16'h0030, 8'h00, 1);
		wr(0, 16'h0031, 8'h00, 1);
	endtask
	task automatic t_alias;
		rdc(1, 16'h0110, 8'h40);
		cfg_load(16'hBEEF);
		cfg_load(16'h1111);
		rdc(1, 16'h0110, 8'h45);
		chk("alias", 16'hBEEF, ALIAS_O);
		chk("ram access", 16'h0001, 16'(RAM_ACCESS_O));
		HOST_OPER_I <= 1'b0;
		rdc(1, 16'h0110, 8'h44);
		chk("ram access", 16'h0000, 16'(RAM_ACCESS_O));
		HOST_OPER_I <= 1'b1;
		wr(1, 16'h0012, 8'h22, 1);
		wr(0, 16'h0013, 8'h33, 1);
		wr(0, 16'h0103, 8'hFF, 1);
		rdc(0, 16'h0103, 8'h01);
		chk("alias", 16'hBE22, ALIAS_O);
		chk("alias enable", 16'h0001, 16'(ALIAS_EN_O));
		rdc(1, 16'h0111, 8'h45);
		chk("event clear", 16'h0000, 16'(ev_cnt));
		rdc(0, 16'h0110, 8'h45);
		rdc(1, 16'h0108, 8'h00);
		chk("event clear", 16'h0001, 16'(ev_cnt));
	endtask
	task automatic t_offset_loop;
		wr(0, 16'h0108, 8'h22, 1);
		wr(0, 16'h0109, 8'h11, 1);
		NET_RW_CMD_I <= 1'b1;
		rdc(0, 16'h0010, 8'h56);
		NET_RW_CMD_I <= 1'b0;
		chk("rw address", 16'h1132, WR_ADR_O);
		wr(0, 16'h0101, 8'h0E, 1);
		rdc(0, 16'h0101, 8'h0E);
		chk("ports", 16'h0005, 16'(PORT_OPEN_O));
		PORT_BUSY_I <= 4'h1;
		wr(0, 16'h0101, 8'h0F, 1);
		rdc(0, 16'h0101, 8'h0F);
		chk("ports", 16'h0005, 16'(PORT_OPEN_O));
		PORT_BUSY_I <= 4'h0;
		rdc(0, 16'h0101, 8'h0F);
		chk("ports", 16'h0004, 16'(PORT_OPEN_O));
	endtask
	task automatic t_keys;
		wr(0, 16'h0040, 8'h52, 1);
		rdc(0, 16'h0040, 8'h01);
		frame_end();
		wr(0, 16'h0040, 8'h45, 1);
		rdc(0, 16'h0040, 8'h02);
		frame_end();
		wr(0, 16'h0040, 8'h53, 1);
		rdc(0, 16'h0040, 8'h00);
		chk("reset count", 16'h0001, 16'(rst_cnt));
		wr(0, 16'h0040, 8'h52, 1);
		wr(0, 16'h0040, 8'h11, 1);
		rdc(0, 16'h0040, 8'h00);
		wr(1, 16'h0041, 8'h52, 1);
		rdc(1, 16'h0041, 8'h01);
		wr(1, 16'h0041, 8'h45, 1);
		rdc(1, 16'h0041, 8'h02);
		wr(1, 16'h0041, 8'h53, 1);
		rdc(1, 16'h0041, 8'h00);
		chk("reset count", 16'h0002, 16'(rst_cnt));
	endtask
	task automatic idle(input int c);
		repeat (c) @(posedge REF_CLK_I);
		#1;
	endtask
	task automatic t_temp_loop;
		wr(0, 16'h0100, 8'h02, 1);
		wr(0, 16'h0101, 8'h00, 1);
		rdc(0, 16'h0101, 8'h00);
		idle(25);
		rdc(0, 16'h0101, 8'h0F);
		wr(0, 16'h0100, 8'h00, 1);
		wr(0, 16'h0101, 8'h10, 1);
		idle(3);
		chk("ports", 16'h0004, 16'(PORT_OPEN_O));
		LINK_UP_I <= 4'h0;
		idle(3);
		chk("ports", 16'h0000, 16'(PORT_OPEN_O));
		LINK_UP_I <= 4'h4;
		idle(3);
		chk("ports", 16'h0000, 16'(PORT_OPEN_O));
		PORT_VALID_RX_I <= 4'h4;
		idle(1);
		PORT_VALID_RX_I <= 4'h0;
		idle(3);
		chk("ports", 16'h0004, 16'(PORT_OPEN_O));
	endtask
	task automatic t_rerun;
		@(posedge REF_CLK_I);
		RST_N_I <= 1'b0;
		repeat (4) @(posedge REF_CLK_I);
		RST_N_I <= 1'b1;
		#1;
		chk("alias", 16'h0000, ALIAS_O);
		chk("fifo", 16'h0007, 16'(FIFO_SIZE_O));
		rdc(1, 16'h0110, 8'h40);
		cfg_load(16'h1357);
		idle(3);
		chk("alias", 16'h1357, ALIAS_O);
		rdc(1, 16'h0110, 8'h45);
		rdc(0, 16'h0010, 8'h00);
	endtask
	initial begin
		repeat (4) @(posedge REF_CLK_I);
		RST_N_I <= 1'b1;
		t_reset();
		t_station();
		t_alias();
		t_offset_loop();
		t_temp_loop();
		t_keys();
		t_rerun();
		test_done();
	end
endmodule
bind slr_regs slr_regs_asserts u_chk (.*);
